// ---- hdl/midi_style_uart.sv ----
// Host-programmable asynchronous serial port with command/status and data registers
//
// How it works
// RL1: Select low with address zero reaches command/status, address one reaches data.
// RL2: Reset leaves rate code 11, port idle until a real rate is written.
// RL3: Writing rate code 11 clears the transmit and receive engines and flags; both data buffers keep their value.
// RL4: Rate codes 00, 01, 10 give 9.6, 31.25, 38.4 kHz both ways.
// RL5: Command bits six and five steer transmit interrupt, RTS level and break.
// RL6: 00 RTS low, 01 RTS low plus interrupt, 10 RTS high, 11 break.
// RL7: Receive enable bit raises interrupt on full buffer or overrun.
// RL8: Receive-full flag sets on a new character, clears on data read.
// RL9: Transmit-empty flag clears on data write, sets when shifter takes it.
// RL10: Status bit three shows the clear-to-send pin level directly.
// RL11: Clear-to-send high forces the transmit-empty status bit to zero.
// RL12: Framing flag marks a missing first stop bit, kept with its character.
// RL13: Overrun flag sets on overwrite of unread data, clears on data read.
// RL14: Status bit seven shows the pending interrupt request.
// RL15: Data writes fill the transmit buffer; data reads return the receive buffer.
// RL16: Frame is low start, eight bits LSB first, high stop, idle high.
module midi_style_uart
  import uart_pkg::*;
(
  input wire logic sys_clk, // System clock, 50 MHz
  input wire logic rst_b, // Master reset, active low
  input wire logic serial_port_select_n, // Port select, active low
  input wire logic hostA0, // Register address bit
  input wire logic hostRdN, // Read strobe, active low
  input wire logic hostWrN, // Write strobe, active low
  input wire logic [7:0] hostDataIn, // Data bus from host
  output logic [7:0] hostDataOut, // Data bus to host
  output logic hostDataOe, // Drive enable for the data bus
  output logic uartIrq, // Interrupt request, active high
  input wire logic serialRx, // Serial receive line
  output logic serialTx, // Serial transmit line
  input wire logic ctsN, // Clear to send, active low
  output logic rtsN // Request to send, active low
);
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  function automatic logic [3:0] nextTick(input logic [3:0] cur);
    return cur + 4'h1;
  endfunction

  baud_if baud();

  uart_baud_gen baudGen (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .baud(baud)
  );

  // Pin synchroniser; the first stage feeds only the second
  logic [SYNC_W-1:0] pinsRaw;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;

  assign pinsRaw = {serial_port_select_n, hostA0, hostRdN, hostWrN, serialRx, ctsN, hostDataIn};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= SYNC_IDLE;
      sync_q <= SYNC_IDLE;
    end else begin
      meta_q <= pinsRaw;
      sync_q <= meta_q;
    end
  end

  logic selN;
  logic addrBit;
  logic rdN;
  logic wrN;
  logic rxLine;
  logic ctsLine;
  logic [7:0] dataPins;

  assign {selN, addrBit, rdN, wrN, rxLine, ctsLine, dataPins} = sync_q;

  // Host strobes; an access takes effect when its strobe is released
  logic rdActive;
  logic wrActive;
  logic rdPrev_q;
  logic wrPrev_q;
  logic rdAddr_q;
  logic wrAddr_q;
  logic [7:0] wrData_q;
  logic rdEnd;
  logic wrEnd;

  assign rdActive = !selN && !rdN;
  assign wrActive = !selN && !wrN;
  assign rdEnd = rdPrev_q && !rdActive;
  assign wrEnd = wrPrev_q && !wrActive;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdPrev_q <= 1'b0;
      wrPrev_q <= 1'b0;
    end else begin
      rdPrev_q <= rdActive;
      wrPrev_q <= wrActive;
    end
  end

  // Address and data are held from the last sampled cycle of the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdAddr_q <= ADDR_CMD_STATUS;
      wrAddr_q <= ADDR_CMD_STATUS;
      wrData_q <= 8'h00;
    end else begin
      if (rdActive) begin
        rdAddr_q <= addrBit;
      end
      if (wrActive) begin
        wrAddr_q <= addrBit;
        wrData_q <= dataPins;
      end
    end
  end

  logic cmdWrite;
  logic dataWrite;
  logic dataRead;

  assign cmdWrite = wrEnd && (wrAddr_q == ADDR_CMD_STATUS); // RL1
  assign dataWrite = wrEnd && (wrAddr_q == ADDR_DATA); // RL1
  assign dataRead = rdEnd && (rdAddr_q == ADDR_DATA); // RL1

  // Command register
  logic [1:0] rate_q;
  logic [1:0] txCtl_q;
  logic rxIe_q;
  logic portIdle;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_q <= RATE_RESET; // RL2
      txCtl_q <= TC_RESET;
      rxIe_q <= RX_IRQ_RESET;
    end else if (cmdWrite) begin
      rate_q <= wrData_q[CMD_RATE_LSB +: 2]; // RL3
      txCtl_q <= wrData_q[CMD_TC_LSB +: 2]; // RL5
      rxIe_q <= wrData_q[CMD_RX_IRQ_BIT];
    end
  end

  // Code 11 holds every engine and the receive-full, framing, overrun and transmit-full bits cleared until a rate is chosen
  assign portIdle = (rate_q == RATE_RESET); // RL2 RL3
  assign baud.rateSel = rate_q; // RL4
  assign baud.run = !portIdle; // RL2

  logic tick;
  assign tick = baud.tick;

  // Transmitter
  tx_state_t txState_q;
  logic txFull_q;
  logic [7:0] txBuf_q;
  logic [9:0] txShift_q;
  logic [3:0] txTick_q;
  logic [3:0] txBit_q;
  logic txLoad;
  logic txBitEnd;
  logic txBreak;
  logic txEmpty;

  // Character leaves the buffer only while the far end is ready
  assign txLoad = (txState_q == TX_IDLE) && txFull_q && !ctsLine && tick;
  assign txBitEnd = (txState_q == TX_SHIFT) && tick && (txTick_q == TICK_LAST);
  assign txBreak = (txCtl_q == TC_BREAK); // RL6
  assign txEmpty = !txFull_q && !ctsLine; // RL11

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txFull_q <= 1'b0;
      txBuf_q <= 8'h00;
    end else if (portIdle) begin
      txFull_q <= 1'b0; // RL3
    end else if (dataWrite) begin
      txFull_q <= 1'b1; // RL9
      txBuf_q <= wrData_q; // RL15
    end else if (txLoad) begin
      txFull_q <= 1'b0; // RL9
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txState_q <= TX_IDLE;
      txShift_q <= 10'h3ff;
      txTick_q <= 4'h0;
      txBit_q <= 4'h0;
    end else if (portIdle) begin
      txState_q <= TX_IDLE; // RL3
      txShift_q <= 10'h3ff;
      txTick_q <= 4'h0;
      txBit_q <= 4'h0;
    end else if (txLoad) begin
      txState_q <= TX_SHIFT;
      txShift_q <= {1'b1, txBuf_q, 1'b0}; // RL16
      txTick_q <= 4'h0;
      txBit_q <= 4'h0;
    end else if (txBitEnd) begin
      txShift_q <= {1'b1, txShift_q[9:1]}; // RL16
      txTick_q <= 4'h0;
      txBit_q <= nextTick(txBit_q);
      if (txBit_q == TX_LAST_BIT) begin
        txState_q <= TX_IDLE;
      end
    end else if ((txState_q == TX_SHIFT) && tick) begin
      txTick_q <= nextTick(txTick_q);
    end
  end

  // Break overrides the line; a character in flight keeps its timing underneath
  logic txLine_d;
  logic txLine_q;
  logic rtsN_q;

  assign txLine_d = txBreak ? 1'b0 : ((txState_q == TX_SHIFT) ? txShift_q[0] : 1'b1); // RL6 RL16

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txLine_q <= 1'b1;
      rtsN_q <= 1'b0;
    end else begin
      txLine_q <= txLine_d;
      rtsN_q <= (txCtl_q == TC_RTS_HIGH); // RL6
    end
  end

  assign serialTx = txLine_q;
  assign rtsN = rtsN_q;

  // Receiver: start bit confirmed at mid-bit, then one sample per bit time
  rx_state_t rxState_q;
  logic [3:0] rxTick_q;
  logic [2:0] rxBit_q;
  logic [7:0] rxShift_q;
  logic rxDone;

  assign rxDone = (rxState_q == RX_STOP) && tick && (rxTick_q == TICK_LAST);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxState_q <= RX_IDLE;
      rxTick_q <= 4'h0;
      rxBit_q <= 3'h0;
      rxShift_q <= 8'h00;
    end else if (portIdle) begin
      rxState_q <= RX_IDLE; // RL3
      rxTick_q <= 4'h0;
      rxBit_q <= 3'h0;
    end else if (tick) begin
      rxTick_q <= nextTick(rxTick_q);
      unique case (rxState_q)
        RX_IDLE: begin
          rxTick_q <= 4'h0;
          if (!rxLine) begin
            rxState_q <= RX_START;
          end
        end
        RX_START: begin
          if (rxTick_q == TICK_MID) begin
            rxTick_q <= 4'h0;
            rxBit_q <= 3'h0;
            rxState_q <= rxLine ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxTick_q == TICK_LAST) begin
            rxShift_q <= {rxLine, rxShift_q[7:1]}; // RL16
            rxBit_q <= rxBit_q + 3'h1;
            if (rxBit_q == RX_LAST_BIT) begin
              rxState_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rxTick_q == TICK_LAST) begin
            rxState_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive buffer and flags; a new character wins over a same-cycle read
  logic [7:0] rxData_q;
  logic rxFull_q;
  logic frameErr_q;
  logic overrun_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxData_q <= 8'h00;
      frameErr_q <= 1'b0;
    end else if (portIdle) begin
      frameErr_q <= 1'b0; // RL3
    end else if (rxDone) begin
      rxData_q <= rxShift_q; // RL15
      frameErr_q <= !rxLine; // RL12
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxFull_q <= 1'b0;
      overrun_q <= 1'b0;
    end else if (portIdle) begin
      rxFull_q <= 1'b0; // RL3
      overrun_q <= 1'b0;
    end else begin
      if (rxDone) begin
        rxFull_q <= 1'b1; // RL8
      end else if (dataRead) begin
        rxFull_q <= 1'b0; // RL8
      end
      if (rxDone && rxFull_q) begin
        overrun_q <= 1'b1; // RL13
      end else if (dataRead) begin
        overrun_q <= 1'b0; // RL13
      end
    end
  end

  // Interrupt request
  logic rxIrq;
  logic txIrq;
  logic irq_q;

  assign rxIrq = rxIe_q && (rxFull_q || overrun_q); // RL7
  assign txIrq = (txCtl_q == TC_RTS_LOW_IRQ) && txEmpty; // RL5 RL6

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= rxIrq || txIrq;
    end
  end

  assign uartIrq = irq_q;

  // Status byte; unused bits read as zero
  logic [7:0] statusByte;

  always_comb begin
    statusByte = 8'h00;
    statusByte[ST_RX_FULL_BIT] = rxFull_q; // RL8
    statusByte[ST_TX_EMPTY_BIT] = txEmpty; // RL9 RL11
    statusByte[ST_CTS_BIT] = ctsLine; // RL10
    statusByte[ST_FRAME_ERR_BIT] = frameErr_q; // RL12
    statusByte[ST_OVERRUN_BIT] = overrun_q; // RL13
    statusByte[ST_IRQ_BIT] = irq_q; // RL14
  end

  // Read data follows the live state while the read strobe is held
  logic [7:0] readData;
  logic [7:0] dataOut_q;

  assign readData = (addrBit == ADDR_DATA) ? rxData_q : statusByte; // RL1 RL15

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dataOut_q <= 8'h00;
    end else if (rdActive) begin
      dataOut_q <= readData;
    end
  end

  assign hostDataOut = dataOut_q;
  assign hostDataOe = rdPrev_q;
endmodule

// ---- hdl/uart_baud_gen.sv ----
// Oversampling tick divider for the three selectable bit rates
module uart_baud_gen
  import uart_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Asynchronous reset, active low
  baud_if.gen baud // Rate select in, tick out
);
  logic [DIV_W-1:0] count_q;
  logic [DIV_W-1:0] count_d;
  logic [DIV_W-1:0] lastCount;
  logic atLast;
  logic tick_q;

  assign lastCount = (baud.rateSel == RATE_31K25) ? DIV_31K25 :
                     (baud.rateSel == RATE_38K4) ? DIV_38K4 : DIV_9K6;
  assign atLast = (count_q >= lastCount);
  assign count_d = (!baud.run || atLast) ? '0 : count_q + DIV_W'(1);
  assign baud.tick = tick_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
      tick_q <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q <= baud.run && atLast;
    end
  end
endmodule

// ---- pkg/baud_if.sv ----
// Link between the port logic and its bit-rate divider
interface baud_if;
  logic [1:0] rateSel;
  logic run;
  logic tick;
  modport gen (input rateSel, input run, output tick);
  modport user (output rateSel, output run, input tick);
endinterface

// ---- pkg/uart_pkg.sv ----
// Constants shared by the serial port and its bit-rate divider
package uart_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned RATE_9K6_HZ = 9600;
  localparam int unsigned RATE_31K25_HZ = 31250;
  localparam int unsigned RATE_38K4_HZ = 38400;
  localparam int DIV_W = 9;
  // Terminal counts of the oversampling divider (period minus one)
  localparam logic [DIV_W-1:0] DIV_9K6 = DIV_W'(CLK_HZ / (RATE_9K6_HZ * OVERSAMPLE) - 1);
  localparam logic [DIV_W-1:0] DIV_31K25 = DIV_W'(CLK_HZ / (RATE_31K25_HZ * OVERSAMPLE) - 1);
  localparam logic [DIV_W-1:0] DIV_38K4 = DIV_W'(CLK_HZ / (RATE_38K4_HZ * OVERSAMPLE) - 1);

  // Register addresses (address bit zero)
  localparam logic ADDR_CMD_STATUS = 1'b0;
  localparam logic ADDR_DATA = 1'b1;

  // Command fields
  localparam int CMD_RATE_LSB = 0;
  localparam int CMD_TC_LSB = 5;
  localparam int CMD_RX_IRQ_BIT = 7;
  localparam logic [1:0] RATE_9K6 = 2'h0;
  localparam logic [1:0] RATE_31K25 = 2'h1;
  localparam logic [1:0] RATE_38K4 = 2'h2;
  localparam logic [1:0] RATE_RESET = 2'h3;
  localparam logic [1:0] TC_RTS_LOW = 2'h0;
  localparam logic [1:0] TC_RTS_LOW_IRQ = 2'h1;
  localparam logic [1:0] TC_RTS_HIGH = 2'h2;
  localparam logic [1:0] TC_BREAK = 2'h3;
  localparam logic [1:0] TC_RESET = TC_RTS_LOW;
  localparam logic RX_IRQ_RESET = 1'b0;

  // Status fields
  localparam int ST_RX_FULL_BIT = 0;
  localparam int ST_TX_EMPTY_BIT = 1;
  localparam int ST_CTS_BIT = 3;
  localparam int ST_FRAME_ERR_BIT = 4;
  localparam int ST_OVERRUN_BIT = 5;
  localparam int ST_IRQ_BIT = 7;

  // Pin synchroniser: {select_n, a0, rd_n, wr_n, rx, cts_n, data[7:0]}
  localparam int SYNC_W = 14;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 14'h2f00;

  // Character timing in oversampling ticks and bit counts
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TX_LAST_BIT = 4'h9;
  localparam logic [2:0] RX_LAST_BIT = 3'h7;
endpackage

// ---- testbench/far_serial.sv ----
// Far-end serial device: sends framed characters, captures the port's output
module far_serial #(
  parameter int BIT_CLKS = 1296
) (
  input wire logic sys_clk, // System clock
  input wire logic serialTx, // Line from the port
  output logic serialRx, // Line into the port, idles high
  output logic ctsN // Ready to accept, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serialRx = 1'b1;
    ctsN = 1'b0;
  end
  task automatic setReady(input logic ready);
    @(posedge sys_clk);
    ctsN <= ~ready;
  endtask
  // Stop level is a choice so a framing fault can be sent on purpose
  task automatic sendChar(input logic [7:0] d, input logic stopLvl);
    logic [10:0] frame;
    frame = {1'b1, stopLvl, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge sys_clk);
      serialRx <= frame[i];
      repeat (BIT_CLKS - 1) @(posedge sys_clk);
    end
  endtask
  task automatic getChar(output logic [7:0] d, output logic stopOk);
    int n;
    n = 0;
    while (serialTx !== 1'b0 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge sys_clk);
      d[i] = serialTx;
    end
    repeat (BIT_CLKS) @(posedge sys_clk);
    stopOk = serialTx;
  endtask
endmodule

// ---- testbench/midi_style_uart_monitor.sv ----
// Checker on the serial port's top-level pins
module midi_style_uart_monitor
  import uart_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Master reset, active low
  input wire logic serial_port_select_n, // Port select
  input wire logic hostA0, // Register address
  input wire logic hostRdN, // Read strobe
  input wire logic hostWrN, // Write strobe
  input wire logic [7:0] hostDataIn, // Host write data
  input wire logic [7:0] hostDataOut, // Host read data
  input wire logic hostDataOe, // Bus drive enable
  input wire logic uartIrq, // Interrupt request
  input wire logic serialRx, // Serial input
  input wire logic serialTx, // Serial output
  input wire logic ctsN, // Clear to send
  input wire logic rtsN // Request to send
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  reset_idle_a: assert property ($rose(rst_b) |-> serialTx && !rtsN && !uartIrq && !hostDataOe)
    else $error("Outputs not idle after reset");
  read_enable_a: assert property ($rose(hostDataOe) |-> $past(!hostRdN && !serial_port_select_n, 2))
    else $error("Bus driven without a selected read");
  oe_release_a: assert property (hostRdN [*4] |-> !hostDataOe)
    else $error("Bus still driven after read ended");
  tx_low_hold_a: assert property ($fell(serialTx) |-> !serialTx [*8])
    else $error("Short low bit on serial output");
  tx_high_hold_a: assert property ($rose(serialTx) |-> serialTx [*8])
    else $error("Short high bit on serial output");
  // Data is held at least four edges past a write, so the commit sees it
  rts_high_a: assert property ($rose(rtsN) |->
    $past(hostDataIn[6:5], 4) == TC_RTS_HIGH && !$past(hostA0, 4))
    else $error("RTS raised without control code 10");
  rts_low_a: assert property ($fell(rtsN) |->
    $past(hostDataIn[6:5], 4) != TC_RTS_HIGH && !$past(hostA0, 4))
    else $error("RTS lowered by control code 10");
  status_bits_a: assert property (hostDataOe && !$past(hostA0, 2) && !$past(hostA0, 3) |->
    !hostDataOut[2] && !hostDataOut[6] && hostDataOut[ST_CTS_BIT] == $past(ctsN, 3))
    else $error("Bad unused or CTS status bit");

  cover property ($rose(hostDataOe));
  cover property ($rose(uartIrq));
  cover property ($rose(rtsN));
  cover property ($fell(serialTx));
endmodule

// ---- testbench/midi_style_uart_tb.sv ----
// Register-level tests of the serial port against a far-end model
module midi_style_uart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_pkg::*;
  logic sys_clk, rst_b, serial_port_select_n, hostA0, hostRdN, hostWrN;
  logic serialRx, serialTx, ctsN, rtsN, hostDataOe, uartIrq;
  logic [7:0] hostDataIn, hostDataOut;
  int num_errors, tests_run;
  logic [1:0] rateCode [3] = '{RATE_9K6, RATE_31K25, RATE_38K4};
  int bitClks [3] = '{16 * 325, 16 * 100, 16 * 81};
  logic [2:0] pinExp [4] = '{3'h1, 3'h3, 3'h5, 3'h0};
  logic [7:0] stExp [4] = '{8'h02, 8'h82, 8'h02, 8'h02};

  midi_style_uart u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .serial_port_select_n(serial_port_select_n), .hostA0(hostA0), .hostRdN(hostRdN),
    .hostWrN(hostWrN), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .uartIrq(uartIrq), .serialRx(serialRx),
    .serialTx(serialTx), .ctsN(ctsN), .rtsN(rtsN));
  far_serial #(.BIT_CLKS(16 * 81)) u_far (.sys_clk(sys_clk), .serialTx(serialTx),
    .serialRx(serialRx), .ctsN(ctsN));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Strobes held five edges low and four high, well past the synchroniser
  task automatic access(input logic wr, input logic a0, input logic [7:0] wd,
    output logic [7:0] q);
    @(posedge sys_clk);
    serial_port_select_n <= 1'b0;
    hostA0 <= a0;
    if (wr) hostDataIn <= wd;
    hostWrN <= ~wr;
    hostRdN <= wr;
    repeat (4) @(posedge sys_clk);
    #1;
    q = hostDataOut;
    if (!wr) check({15'h0, hostDataOe}, 16'h1);
    @(posedge sys_clk);
    serial_port_select_n <= 1'b1;
    hostWrN <= 1'b1;
    hostRdN <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic wrReg(input logic a0, input logic [7:0] d);
    logic [7:0] q;
    access(1'b1, a0, d, q);
  endtask
  task automatic rdReg(input logic a0, input logic [7:0] exp);
    logic [7:0] q;
    access(1'b0, a0, 8'h00, q);
    check({8'h00, q}, {8'h00, exp});
  endtask
  task automatic waitTx(input logic lvl);
    int k;
    k = 0;
    while (serialTx !== lvl && k < 8000) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    logic [7:0] d;
    logic ok;
    int n;
    {serial_port_select_n, hostA0, hostRdN, hostWrN, rst_b} = 5'h16;
    hostDataIn = 8'h00;
    num_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdReg(ADDR_CMD_STATUS, 8'h02);
    check({14'h0, serialTx, rtsN}, 16'h2);
    wrReg(ADDR_DATA, 8'h55);
    repeat (2000) @(posedge sys_clk);
    check({15'h0, serialTx}, 16'h1);
    $display("Test reset done");
    for (int i = 0; i < 3; i++) begin
      wrReg(ADDR_CMD_STATUS, {3'h0, 3'h0, rateCode[i]});
      wrReg(ADDR_DATA, 8'h01);
      waitTx(1'b0);
      n = 0;
      while (serialTx === 1'b0 && n < 6000) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      check(16'(n), 16'(bitClks[i]));
      // Bit one is low: a reset now must lift the line mid-character
      waitTx(1'b0);
      wrReg(ADDR_CMD_STATUS, 8'h03);
      repeat (2) @(posedge sys_clk);
      #1;
      check({15'h0, serialTx}, 16'h1);
    end
    $display("Test rates done");
    for (int t = 0; t < 4; t++) begin
      wrReg(ADDR_CMD_STATUS, {1'b0, 2'(t), 3'h0, RATE_38K4});
      repeat (4) @(posedge sys_clk);
      #1;
      check({13'h0, rtsN, uartIrq, serialTx}, {13'h0, pinExp[t]});
      rdReg(ADDR_CMD_STATUS, stExp[t]);
    end
    $display("Test control done");
    u_far.setReady(1'b0);
    wrReg(ADDR_CMD_STATUS, {1'b0, TC_RTS_LOW, 3'h0, RATE_38K4});
    wrReg(ADDR_DATA, 8'ha5);
    repeat (3000) @(posedge sys_clk);
    #1;
    check({15'h0, serialTx}, 16'h1);
    rdReg(ADDR_CMD_STATUS, 8'h08);
    u_far.setReady(1'b1);
    fork
      u_far.getChar(d, ok);
      begin
        repeat (3000) @(posedge sys_clk);
        wrReg(ADDR_DATA, 8'h3c);
        rdReg(ADDR_CMD_STATUS, 8'h00);
      end
    join
    check({7'h0, ok, d}, 16'h1a5);
    u_far.getChar(d, ok);
    check({7'h0, ok, d}, 16'h13c);
    rdReg(ADDR_CMD_STATUS, 8'h02);
    $display("Test transmit done");
    wrReg(ADDR_CMD_STATUS, {1'b1, TC_RTS_LOW, 3'h0, RATE_38K4});
    u_far.sendChar(8'h3c, 1'b1);
    check({15'h0, uartIrq}, 16'h1);
    rdReg(ADDR_CMD_STATUS, 8'h83);
    rdReg(ADDR_DATA, 8'h3c);
    rdReg(ADDR_CMD_STATUS, 8'h02);
    u_far.sendChar(8'hc3, 1'b1);
    u_far.sendChar(8'h5a, 1'b0);
    rdReg(ADDR_CMD_STATUS, 8'hb3);
    rdReg(ADDR_DATA, 8'h5a);
    rdReg(ADDR_CMD_STATUS, 8'h12);
    wrReg(ADDR_CMD_STATUS, 8'h03);
    rdReg(ADDR_CMD_STATUS, 8'h02);
    $display("Test receive done");
    end_of_test();
  end
endmodule

bind midi_style_uart midi_style_uart_monitor u_mon (.sys_clk(sys_clk), .rst_b(rst_b),
  .serial_port_select_n(serial_port_select_n), .hostA0(hostA0), .hostRdN(hostRdN),
  .hostWrN(hostWrN), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
  .hostDataOe(hostDataOe), .uartIrq(uartIrq), .serialRx(serialRx),
  .serialTx(serialTx), .ctsN(ctsN), .rtsN(rtsN));
